//--- core/ecp_ctl_pkg.sv
// What this block does
// - Capability B bit 7 always reads zero: no hardware compression.
// - Capability B bit 6 shows the live interrupt request line level.
// - Capability B bits 5:0 read zero and ignore writes.
// - Mode field sits in control bits 7:5, read/write, eight encodings.
// - In ECP mode, fault falling edge with disable clear, or disable cleared with fault low, interrupts.
// - DMA runs only with DMA allowed and service mask clear.
// - Service mask set blocks DMA and service interrupts; writing one never interrupts.
// - A service interrupt sets the mask; software clears it to re-arm.
// - With DMA allowed, terminal count sets mask and interrupts.
// - DMA off, forward: free bytes at threshold or more sets mask and interrupts.
// - DMA off, reverse: valid bytes at threshold or more sets mask and interrupts.
// - Control bit 1 reads one when the queue cannot take a byte.
// - Control bit 0 reads one when the queue holds no data.
// - Standard mode resets the queue, control lines open-collector, data always driven.
// - Byte mode: direction floats data lines, live lines readable, push-pull drivers.
// - Queue mode sends queued bytes with the compatibility handshake, forward only.
// - ECP mode sends address and data bytes forward, collects bytes in reverse.
// - EPP mode is active only when the chip option enables it; push-pull.
// - Test mode: queue host readable and writable, nothing sent on the lines.
// - Configuration mode maps capability A and B at the queue offset and next.
// - Mode changes only via standard or byte mode; direction changes only in byte mode.
// - Leaving ECP reverse releases host acknowledge at once and drops surplus bytes.
// - Direction zero is output, one input; forced output in modes 000 and 010.
// - The threshold setting is one less than the effective threshold.
// - Each interrupt is a brief low pulse, then the line is released.
package ecp_ctl_pkg;
    localparam logic [10:0] OFS_AFIFO = 11'h000;
    localparam logic [10:0] OFS_FIFO  = 11'h400;
    localparam logic [10:0] OFS_CAPB  = 11'h401;
    localparam logic [10:0] OFS_ECR   = 11'h402;
    localparam int ECR_MODE_LSB = 5;
    localparam int ECR_FDIS     = 4;
    localparam int ECR_DMA      = 3;
    localparam int ECR_MASK     = 2;
    localparam int ECR_FULL     = 1;
    localparam int ECR_EMPTY    = 0;
    localparam int CAPB_IRQ     = 6;
    localparam logic [7:0] ECR_RST  = 8'h04;
    localparam logic [7:0] CAPA_VAL = 8'h10;
    localparam logic [11:0] PIN_IDLE = 12'hd00;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    localparam int CLK_MHZ      = 250;
    localparam int IRQ_PULSE_NS = 100;
    localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int HS_NS        = 100;
    localparam int HS_CYC       = (HS_NS * CLK_MHZ + 999) / 1000;
    localparam int DMA_GAP_NS   = 350;
    localparam int DMA_GAP_CYC  = (DMA_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int DMA_BURST    = 32;
    typedef enum logic [2:0] {
        M_STD, M_BYTE, M_FIFO, M_ECP, M_EPP, M_RSVD, M_TEST, M_CFG
    } port_mode_t;
    typedef enum logic [2:0] {
        HS_IDLE, HS_SETUP, HS_PULSE, HS_WAIT, HS_RWAIT, HS_RREL
    } hs_state_t;
endpackage

//--- core/ecp_port_ctl.sv
`timescale 1ns/1ps
module ecp_port_ctl
    import ecp_ctl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    input  wire logic [10:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        dack_i,
    input  wire logic        tc_i,
    output logic             dreq_o,
    input  wire logic        irq_line_i,
    output logic             irq_o,
    output logic             irq_oe_o,
    input  wire logic [7:0]  pd_i,
    output logic      [7:0]  pd_o,
    output logic             pd_oe_o,
    output logic      [7:0]  line_data_o,
    input  wire logic [7:0]  spp_data_i,
    input  wire logic        dir_bit_i,
    input  wire logic [3:0]  ctl_bits_i,
    output logic      [3:0]  ctl_o,
    output logic      [3:0]  ctl_oe_o,
    input  wire logic        periph_error_line_i,
    input  wire logic        busy_i,
    input  wire logic        periph_ack_line_i,
    input  wire logic [3:0]  queue_level_setting_i,
    input  wire logic        epp_option_i,
    output logic             epp_active_o
);
    // Pin synchronisers: only the second stage is read by logic.
    logic [11:0] s1_q, s2_q;
    logic        flt_prev_q;
    wire  [11:0] pins_raw = {irq_line_i, periph_error_line_i, busy_i,
                             periph_ack_line_i, pd_i};
    wire  [7:0]  pd_s   = s2_q[7:0];
    wire         pack_s = s2_q[8];
    wire         busy_s = s2_q[9];
    wire         flt_s  = s2_q[10];
    wire         irq_s  = s2_q[11];

    port_mode_t mode_q;
    logic fdis_q, dma_q, mask_q, dir_q;
    logic [8:0] mem_q [16];
    logic [3:0] wp_q, rp_q;
    logic [4:0] cnt_q;
    logic [8:0] b0_q, b1_q;
    logic [1:0] bcnt_q;
    hs_state_t  st_q;
    logic [7:0] hcnt_q;
    logic       hc_q, ha_q;
    logic [7:0] pd_q, rev_q, rdata_q;
    logic [3:0] lvl_q;
    logic [7:0] irq_cnt_q;
    logic [5:0] burst_q;
    logic [7:0] gap_q;

    // Address decode and mode groups.
    wire is_fifo_md = (mode_q == M_FIFO) || (mode_q == M_ECP) || (mode_q == M_TEST);
    wire is_cfg     = (mode_q == M_CFG);
    wire hit_fifo   = (addr_i == OFS_FIFO) && is_fifo_md;
    wire hit_afifo  = (addr_i == OFS_AFIFO) && (mode_q == M_ECP);
    wire hit_ecr    = (addr_i == OFS_ECR);
    wire ecr_w      = wr_i && hit_ecr && !dack_i;
    wire dir_eff    = (mode_q == M_STD || mode_q == M_FIFO) ? 1'b0 : dir_q;
    wire full       = (cnt_q == FIFO_DEPTH);
    wire empty      = (cnt_q == 5'h00) && (bcnt_q == 2'd0);
    wire fifo_clr   = (mode_q == M_STD) || (mode_q == M_BYTE);

    // Register reads.
    wire [7:0] ecr_rd  = {mode_q, fdis_q, dma_q, mask_q, full, empty};
    wire [7:0] capb_rd = {1'b0, irq_s, 6'h00};
    wire [7:0] rd_mux  = hit_ecr ? ecr_rd :
                         (is_cfg && addr_i == OFS_FIFO) ? CAPA_VAL :
                         (is_cfg && addr_i == OFS_CAPB) ? capb_rd :
                         mem_q[rp_q][7:0];

    // Queue access from the host, by address or by DMA acknowledge.
    wire host_wr   = wr_i && (hit_fifo || hit_afifo || (dack_i && is_fifo_md));
    wire host_rd   = rd_i && (hit_fifo || (dack_i && is_fifo_md));
    wire host_push = host_wr && !full && !fifo_clr;
    wire host_pop  = host_rd && (cnt_q != 5'h00);
    wire host_tag  = hit_afifo && !dack_i;

    // Forward path: queue feeds a two-entry buffer that feeds the line engine.
    wire send_md   = ((mode_q == M_FIFO) || (mode_q == M_ECP)) && !dir_eff;
    wire buf_pop   = (st_q == HS_IDLE) && (bcnt_q != 2'd0) && send_md;
    wire buf_room  = (bcnt_q != 2'd2) || buf_pop;
    wire buf_fill  = send_md && (cnt_q != 5'h00) && buf_room && !host_pop;
    wire rev_push  = (st_q == HS_RREL) && pack_s && !full;
    wire push      = host_push || rev_push;
    wire pop       = host_pop || buf_fill;
    wire [8:0] push_word = rev_push ? {1'b0, rev_q} : {host_tag, wdata_i};

    // Service interrupt condition.
    wire [4:0] thr    = {1'b0, queue_level_setting_i} + 5'h01;
    wire [4:0] free_b = FIFO_DEPTH - cnt_q;
    wire tc_evt   = dack_i && tc_i && (rd_i || wr_i);
    wire svc_cond = dma_q ? tc_evt :
                    (!dir_eff ? (free_b >= thr) :
                                (cnt_q >= thr));
    wire svc_fire = is_fifo_md && !mask_q && svc_cond;
    wire flt_evt  = (mode_q == M_ECP) &&
                    ((!fdis_q && flt_prev_q && !flt_s) ||
                     (ecr_w && fdis_q && !wdata_i[ECR_FDIS] && !flt_s));
    wire irq_evt  = svc_fire || flt_evt;

    // Mode change legality.
    wire [2:0] new_mode = wdata_i[7:5];
    wire mode_ok = (mode_q == M_STD) || (mode_q == M_BYTE) ||
                   (new_mode == 3'd0) || (new_mode == 3'd1);

    // DMA request, held off after a burst until acknowledge has been idle.
    wire burst_end = (burst_q == 6'(DMA_BURST));
    wire dma_room  = dir_eff ? (cnt_q != 5'h00) : !full;
    assign dreq_o  = dma_q && !mask_q && is_fifo_md && !burst_end && dma_room;

    // Interrupt line: drive low for a short pulse, otherwise released.
    assign irq_o        = 1'b0;
    assign irq_oe_o     = (irq_cnt_q != 8'h00);
    assign rdata_o      = rdata_q;
    assign line_data_o  = pd_s;
    assign pd_o         = pd_q;
    assign pd_oe_o      = !dir_eff;
    assign ctl_o        = fifo_clr && mode_q == M_STD ? 4'h0 : lvl_q;
    assign ctl_oe_o     = (mode_q == M_STD) ? ~lvl_q : 4'hf;
    assign epp_active_o = (mode_q == M_EPP) && epp_option_i;

    // Control line levels: the engine owns clock and acknowledge in handshake modes.
    wire hs_md = send_md || ((mode_q == M_ECP) && dir_eff);
    wire [3:0] lvl_d = hs_md ? {~ctl_bits_i[3], ctl_bits_i[2], ha_q, hc_q}
                             : {~ctl_bits_i[3], ctl_bits_i[2],
                                ~ctl_bits_i[1], ~ctl_bits_i[0]};

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            // Synchronisers start at the idle pin levels, so no false fault edge follows reset.
            s1_q       <= PIN_IDLE;
            s2_q       <= PIN_IDLE;
            flt_prev_q <= 1'b1;
            lvl_q      <= 4'hf;
        end else if (ce_i) begin
            s1_q       <= pins_raw;
            s2_q       <= s1_q;
            flt_prev_q <= flt_s;
            lvl_q      <= lvl_d;
        end
    end

    // Extended control register.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_q <= M_STD;
            fdis_q <= ECR_RST[ECR_FDIS];
            dma_q  <= ECR_RST[ECR_DMA];
            mask_q <= ECR_RST[ECR_MASK];
            dir_q  <= 1'b0;
        end else if (ce_i) begin
            if (ecr_w && mode_ok) begin
                mode_q <= port_mode_t'(new_mode);
            end
            if (ecr_w) begin
                fdis_q <= wdata_i[ECR_FDIS];
                dma_q  <= wdata_i[ECR_DMA];
            end
            // The hardware set wins over a software clear in the same cycle.
            if (svc_fire) begin
                mask_q <= 1'b1;
            end else if (ecr_w) begin
                mask_q <= wdata_i[ECR_MASK];
            end
            if (mode_q == M_BYTE) begin
                dir_q <= dir_bit_i;
            end
        end
    end

    // Queue storage: bit 8 tags an address/RLE byte.
    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem_q[wp_q] <= push_word;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wp_q  <= 4'h0;
            rp_q  <= 4'h0;
            cnt_q <= 5'h00;
        end else if (ce_i) begin
            if (fifo_clr) begin
                wp_q  <= 4'h0;
                rp_q  <= 4'h0;
                cnt_q <= 5'h00;
            end else begin
                wp_q  <= wp_q + 4'(push);
                rp_q  <= rp_q + 4'(pop);
                cnt_q <= cnt_q + 5'(push) - 5'(pop);
            end
        end
    end

    // Two-entry buffer between queue and line engine.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            b0_q   <= 9'h000;
            b1_q   <= 9'h000;
            bcnt_q <= 2'd0;
        end else if (ce_i) begin
            if (!send_md) begin
                bcnt_q <= 2'd0;
            end else begin
                bcnt_q <= bcnt_q + 2'(buf_fill) - 2'(buf_pop);
                if (buf_pop) begin
                    b0_q <= (bcnt_q == 2'd2) ? b1_q : mem_q[rp_q];
                end else if (buf_fill && bcnt_q == 2'd0) begin
                    b0_q <= mem_q[rp_q];
                end
                if (buf_fill && (bcnt_q - 2'(buf_pop)) == 2'd1) begin
                    b1_q <= mem_q[rp_q];
                end
            end
        end
    end

    // Line engine: compatibility forward, ECP forward and ECP reverse.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_q   <= HS_IDLE;
            hcnt_q <= 8'h00;
            hc_q   <= 1'b1;
            ha_q   <= 1'b1;
            pd_q   <= 8'h00;
            rev_q  <= 8'h00;
        end else if (ce_i) begin
            if (!hs_md) begin
                st_q <= HS_IDLE;
                hc_q <= 1'b1;
                ha_q <= 1'b1;
                pd_q <= spp_data_i;
            end else begin
                unique case (st_q)
                    HS_IDLE: begin
                        hc_q <= 1'b1;
                        if (buf_pop) begin
                            pd_q   <= b0_q[7:0];
                            ha_q   <= (mode_q == M_ECP) ? !b0_q[8] : 1'b1;
                            hcnt_q <= 8'(HS_CYC);
                            st_q   <= HS_SETUP;
                        end else if (mode_q == M_ECP && dir_eff && !full) begin
                            ha_q <= 1'b0;
                            st_q <= HS_RWAIT;
                        end
                    end
                    HS_SETUP: begin
                        hcnt_q <= hcnt_q - 8'h01;
                        if (hcnt_q == 8'h01) begin
                            hc_q   <= 1'b0;
                            hcnt_q <= 8'(HS_CYC);
                            st_q   <= HS_PULSE;
                        end
                    end
                    HS_PULSE: begin
                        if (hcnt_q != 8'h00) begin
                            hcnt_q <= hcnt_q - 8'h01;
                        end
                        // Compatibility ends the strobe on time; ECP waits for busy.
                        if ((mode_q == M_FIFO && hcnt_q == 8'h00) ||
                            (mode_q == M_ECP && busy_s)) begin
                            hc_q <= 1'b1;
                            st_q <= HS_WAIT;
                        end
                    end
                    HS_WAIT: begin
                        if (!busy_s) begin
                            st_q <= HS_IDLE;
                        end
                    end
                    HS_RWAIT: begin
                        if (!pack_s) begin
                            rev_q <= pd_s;
                            ha_q  <= 1'b1;
                            st_q  <= HS_RREL;
                        end
                    end
                    HS_RREL: begin
                        if (pack_s) begin
                            st_q <= HS_IDLE;
                        end
                    end
                    default: st_q <= HS_IDLE;
                endcase
            end
        end
    end

    // Read data, interrupt pulse and DMA burst limiting.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q   <= 8'h00;
            irq_cnt_q <= 8'h00;
            burst_q   <= 6'h00;
            gap_q     <= 8'h00;
        end else if (ce_i) begin
            // An empty test queue read keeps the previous byte on the bus.
            if (rd_i && !(host_rd && cnt_q == 5'h00)) begin
                rdata_q <= rd_mux;
            end
            if (irq_evt) begin
                irq_cnt_q <= 8'(IRQ_PULSE_CYC);
            end else if (irq_cnt_q != 8'h00) begin
                irq_cnt_q <= irq_cnt_q - 8'h01;
            end
            if (dack_i && (rd_i || wr_i) && !burst_end) begin
                burst_q <= burst_q + 6'h01;
            end
            if (dack_i) begin
                gap_q <= 8'h00;
            end else if (gap_q != 8'(DMA_GAP_CYC)) begin
                gap_q <= gap_q + 8'h01;
            end else begin
                burst_q <= 6'h00;
            end
        end
    end

    // Checks.
    property p_capb_top;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && rd_i && is_cfg && addr_i == OFS_CAPB) |=> rdata_o[7] == 1'b0;
    endproperty
    a_capb_top: assert property (p_capb_top) else $error("capb bit7 set");

    property p_capb_irq;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && rd_i && is_cfg && addr_i == OFS_CAPB) |=> rdata_o[6] == $past(irq_s);
    endproperty
    a_capb_irq: assert property (p_capb_irq) else $error("capb irq level");

    property p_capb_low;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && rd_i && is_cfg && addr_i == OFS_CAPB) |=> rdata_o[5:0] == 6'h00;
    endproperty
    a_capb_low: assert property (p_capb_low) else $error("capb low bits");

    property p_mode_lock;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && ecr_w && !mode_ok) |=> $stable(mode_q);
    endproperty
    a_mode_lock: assert property (p_mode_lock) else $error("illegal mode change");

    property p_mask_blocks;
        @(posedge clk_i) disable iff (reset_i)
        (mask_q || !dma_q) |-> !dreq_o;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("dma while blocked");

    property p_fire_sets;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && svc_fire) |=> mask_q ##0 irq_oe_o;
    endproperty
    a_fire_sets: assert property (p_fire_sets) else $error("mask not set");

    property p_flags;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && rd_i && hit_ecr) |=> rdata_o[1:0] == {$past(full), $past(empty)};
    endproperty
    a_flags: assert property (p_flags) else $error("full/empty flag");

    property p_std_clear;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && mode_q == M_STD) |-> pd_oe_o ##1 (cnt_q == 5'h00);
    endproperty
    a_std_clear: assert property (p_std_clear) else $error("std mode queue");

    property p_irq_pulse;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && irq_evt) |=> irq_oe_o [*8] ##1 irq_oe_o [*8] ##1 irq_oe_o [*8]
                              ##1 irq_oe_o ##[1:400] !irq_oe_o;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse shape");

    c_tc_fire:  cover property (@(posedge clk_i) disable iff (reset_i) svc_fire && dma_q);
    c_fault:    cover property (@(posedge clk_i) disable iff (reset_i) flt_evt);
    c_rev_byte: cover property (@(posedge clk_i) disable iff (reset_i) rev_push);
endmodule

//--- tb/periph_model.sv
`timescale 1ns/1ps
module periph_model (
    input  wire logic       clk_i,
    input  wire logic       host_clock_line_i,
    input  wire logic [7:0] pd_i,
    input  wire logic [7:0] slow_i,
    output logic            busy_o,
    output logic [7:0]      got_o,
    output logic            got_v_o
);
    logic       clk_prev_q = 1'b1;
    logic [7:0] cnt_q      = 8'h00;
    initial begin
        busy_o = 1'b0;
        got_o = 8'h00;
        got_v_o = 1'b0;
    end
    // A byte is taken on the falling host clock; busy then holds off the next one.
    always @(posedge clk_i) begin
        clk_prev_q <= host_clock_line_i;
        got_v_o <= 1'b0;
        if (clk_prev_q && !host_clock_line_i && !busy_o) begin
            got_o <= pd_i;
            got_v_o <= 1'b1;
            busy_o <= 1'b1;
            cnt_q <= slow_i;
        end else if (busy_o && cnt_q == 8'h00) begin
            busy_o <= 1'b0;
        end else if (busy_o) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

//--- tb/tb_ecp_port_mode_and_fifo_control.sv
`timescale 1ns/1ps
module tb_ecp_port_mode_and_fifo_control;
    import ecp_ctl_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1, wr = 1'b0, rd = 1'b0, dack = 1'b0, tc = 1'b0;
    logic dir = 1'b0, epp = 1'b0, fault = 1'b1, busy, got_v, dreq_o, irq_o, irq_oe_o;
    logic pd_oe_o, epp_o;
    logic [10:0] addr = 11'h000;
    logic [7:0]  wdata = 8'h00, compat_mode = 8'h00, rdata_o, pd_o, line_o, got, slow = 8'h00;
    logic [3:0]  ctl = 4'h0, thr = 4'h0, ctl_o, ctl_oe_o;
    logic [31:0] seed = 32'h66;
    logic [7:0]  q[$];
    int failures = 0, num_checks = 0, n;
    wire irq_w = irq_oe_o ? irq_o : 1'b1;
    wire [7:0] pd_w = pd_oe_o ? pd_o : ~pd_o;
    ecp_port_ctl DUT (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o), .dack_i(dack), .tc_i(tc),
        .dreq_o(dreq_o), .irq_line_i(irq_w), .irq_o(irq_o), .irq_oe_o(irq_oe_o), .pd_i(pd_w),
        .pd_o(pd_o), .pd_oe_o(pd_oe_o), .line_data_o(line_o), .spp_data_i(compat_mode),
        .dir_bit_i(dir), .ctl_bits_i(ctl), .ctl_o(ctl_o), .ctl_oe_o(ctl_oe_o),
        .periph_error_line_i(fault), .busy_i(busy), .periph_ack_line_i(1'b1),
        .queue_level_setting_i(thr), .epp_option_i(epp), .epp_active_o(epp_o));
    periph_model u_periph (.clk_i(clk_i), .host_clock_line_i(ctl_o[0]), .pd_i(pd_w),
        .slow_i(slow), .busy_o(busy), .got_o(got), .got_v_o(got_v));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic complete_run;
        if (failures == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask
    task automatic wr_reg(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [10:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask
    task automatic push(input logic [7:0] d);
        wr_reg(OFS_FIFO, d);
        if (q.size() < 16) q.push_back(d);
    endtask
    task automatic irq_pulse(input logic [7:0] len);
        // Let the edge that may load the pulse counter settle before looking.
        #1;
        n = 0;
        repeat (6) if (irq_oe_o !== 1'b1) tick;
        while (irq_oe_o === 1'b1 && n < 40) begin
            check(8'(irq_w), 8'h00);
            n++;
            tick;
        end
        check(8'(n), len);
    endtask
    initial begin
        #300000;
        failures++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd_reg(OFS_ECR, 8'h05);
        for (int m = 0; m < 8; m++) begin
            epp <= xs() % 2;
            wr_reg(OFS_ECR, {m[2:0], 5'h04});
            rd_reg(OFS_ECR, {m[2:0], 5'h05});
            check(8'(epp_o), 8'(m == 4 && epp));
            if (m != 7) wr_reg(OFS_ECR, 8'h04);
        end
        rd_reg(OFS_CAPB, 8'h40);
        wr_reg(OFS_CAPB, 8'hff);
        rd_reg(OFS_CAPB, 8'h40);
        rd_reg(OFS_FIFO, CAPA_VAL);
        wr_reg(OFS_ECR, 8'h64);
        rd_reg(OFS_ECR, 8'he5);
        wr_reg(OFS_ECR, 8'h04);
        dir <= 1'b1;
        ctl <= xs();
        compat_mode <= xs();
        repeat (4) tick;
        check(8'(pd_oe_o), 8'h01);
        check(pd_o, compat_mode);
        check(8'(ctl_oe_o), 8'({ctl[3], ~ctl[2], ctl[1], ctl[0]}));
        check(8'(ctl_o), 8'h00);
        wr_reg(OFS_ECR, 8'h24);
        repeat (4) tick;
        check(8'(pd_oe_o), 8'h00);
        check(line_o, pd_w);
        wr_reg(OFS_ECR, 8'hc4);
        thr <= xs();
        tick;
        repeat (thr) push(xs());
        wr_reg(OFS_ECR, 8'hc0);
        irq_pulse(8'h00);
        push(xs());
        irq_pulse(IRQ_PULSE_CYC);
        wr_reg(OFS_ECR, 8'hc4);
        irq_pulse(8'h00);
        rd_reg(OFS_ECR, q.size() == 16 ? 8'hc6 : 8'hc4);
        while (q.size() < 16) push(xs());
        push(xs());
        rd_reg(OFS_ECR, 8'hc6);
        while (q.size() > 0) rd_reg(OFS_FIFO, q.pop_front());
        rd_reg(OFS_ECR, 8'hc5);
        wr_reg(OFS_ECR, 8'h04);
        dir <= 1'b0;
        wr_reg(OFS_ECR, 8'h24);
        wr_reg(OFS_ECR, 8'hcc);
        #1 check(8'(dreq_o), 8'h00);
        wr_reg(OFS_ECR, 8'hc8);
        #1 check(8'(dreq_o), 8'h01);
        wr_reg(OFS_ECR, 8'hc0);
        #1 check(8'(dreq_o), 8'h00);
        irq_pulse(IRQ_PULSE_CYC);
        wr_reg(OFS_ECR, 8'hc8);
        @(posedge clk_i);
        dack <= 1'b1;
        wr <= 1'b1;
        tc <= 1'b1;
        @(posedge clk_i);
        {dack, wr, tc} <= 3'b000;
        irq_pulse(IRQ_PULSE_CYC);
        check(8'(dreq_o), 8'h00);
        rd_reg(OFS_ECR, 8'hcc);
        wr_reg(OFS_ECR, 8'h04);
        wr_reg(OFS_ECR, 8'h44);
        slow <= xs() % 64;
        for (int i = 0; i < 3; i++) push(xs());
        check(8'(ctl_oe_o), 8'h0f);
        while (q.size() > 0) begin
            n = 0;
            while (got_v !== 1'b1 && n < 2000) begin
                tick;
                n++;
            end
            if (n == 2000) failures++;
            check(got, q.pop_front());
            tick;
        end
        wr_reg(OFS_ECR, 8'h04);
        wr_reg(OFS_ECR, 8'h74);
        @(posedge clk_i) fault <= 1'b0;
        irq_pulse(8'h00);
        wr_reg(OFS_ECR, 8'h64);
        irq_pulse(IRQ_PULSE_CYC);
        @(posedge clk_i) fault <= 1'b1;
        repeat (4) tick;
        @(posedge clk_i) fault <= 1'b0;
        irq_pulse(IRQ_PULSE_CYC);
        rd_reg(OFS_ECR, 8'h65);
        complete_run;
    end
endmodule
